// *** core/tsq_top.sv ***
// Purpose: time-sync event queue, counter and interrupt front end
// Assumes: AHB-Lite slave, single clock core_clk, sync active-high rst
// Notes:   reads take one wait state, writes none
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`default_nettype none
`timescale 1ns/1ps
module tsq_top #(
  parameter int unsigned HW_PUSH_N = 4,
  parameter int unsigned DEPTH     = 16,
  parameter int unsigned LW        = $clog2(DEPTH) + 1
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic [HW_PUSH_N-1:0]  hw_push_pin,
  input  wire logic                  eth_evt_valid,
  input  wire tsq_pkg::tsq_eth_evt_t eth_evt,
  output logic                       irq
);
  logic                       unit_enable_bit;
  logic [tsq_pkg::TSQ_NFLAG-1:0] flag_mask_reg;
  logic                       lost_reg;
  logic [31:0]                ts_cnt_reg;
  logic                       wr_pend_reg;
  logic                       rd_pend_reg;
  logic [7:0]                 acc_addr_reg;
  logic                       hready_reg;
  logic [31:0]                hrdata_reg;
  logic                       irq_reg;
  logic [HW_PUSH_N-1:0]       sync_a_reg;
  logic [HW_PUSH_N-1:0]       sync_b_reg;
  logic [HW_PUSH_N-1:0]       prev_reg;
  logic [HW_PUSH_N-1:0]       hw_rise;
  logic                       addr_ok;
  logic                       wr_ctl;
  logic                       wr_push;
  logic                       wr_raw;
  logic                       wr_mask;
  logic                       wr_disc;
  logic                       sw_push_req;
  logic                       roll_req;
  logic                       half_req;
  logic                       hw_req;
  logic [4:0]                 hw_num;
  logic                       eth_req;
  logic [3:0]                 n_req;
  logic                       cand_valid;
  tsq_pkg::tsq_rec_t          cand_rec;
  logic                       push_ready;
  logic                       push_fire;
  logic                       pop_fire;
  logic                       raw_pending_flag;
  logic                       masked_pending_flag;
  logic                       pending_mask_bit;
  logic [tsq_pkg::TSQ_NFLAG-1:0] raw_irq_flags;
  logic [tsq_pkg::TSQ_NFLAG-1:0] masked_irq_flags;
  logic                       lost_evt;
  tsq_pkg::tsq_rec_t          head_rec;
  tsq_pkg::tsq_desc_t         hi_desc;
  logic [LW-1:0]              q_level;
  logic [31:0]                rd_val;

  // bus address phase
  assign addr_ok = hsel && htrans[tsq_pkg::TSQ_HTRANS_ACT] && hready
                   && (hsize == tsq_pkg::TSQ_HSIZE_WORD);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_pend_reg  <= 1'b0;
      rd_pend_reg  <= 1'b0;
      acc_addr_reg <= 8'h00;
      hready_reg   <= 1'b1;
    end
    else if (addr_ok)
    begin
      wr_pend_reg  <= hwrite;
      rd_pend_reg  <= !hwrite;
      acc_addr_reg <= haddr[tsq_pkg::TSQ_AW-1:0];
      // one wait state so a read sees any write just finished
      hready_reg   <= hwrite;
    end
    else
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hready_reg  <= 1'b1;
    end
  end

  // write decode in the data phase
  assign wr_ctl  = wr_pend_reg && (acc_addr_reg == tsq_pkg::TSQ_OFF_CTL);
  assign wr_push = wr_pend_reg && (acc_addr_reg == tsq_pkg::TSQ_OFF_PUSH);
  assign wr_raw  = wr_pend_reg && (acc_addr_reg == tsq_pkg::TSQ_OFF_RAW);
  assign wr_mask = wr_pend_reg && (acc_addr_reg == tsq_pkg::TSQ_OFF_EN);
  assign wr_disc = wr_pend_reg && (acc_addr_reg == tsq_pkg::TSQ_OFF_DISC);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      unit_enable_bit <= 1'b0;
    end
    else if (wr_ctl)
    begin
      unit_enable_bit <= hwdata[tsq_pkg::TSQ_BIT_EN];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flag_mask_reg <= tsq_pkg::TSQ_FLAG_RST;
    end
    else if (wr_mask)
    begin
      flag_mask_reg <= hwdata[tsq_pkg::TSQ_NFLAG-1:0];
    end
  end

  // time-stamp counter, cleared while the unit is off
  always_ff @(posedge core_clk)
  begin
    if (rst || !unit_enable_bit)
    begin
      ts_cnt_reg <= tsq_pkg::TSQ_CNT_RST;
    end
    else
    begin
      ts_cnt_reg <= ts_cnt_reg + tsq_pkg::TSQ_CNT_ONE;
    end
  end

  // hardware push pins: two-flop sync, then rise detect
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
      prev_reg   <= '0;
    end
    else
    begin
      sync_a_reg <= hw_push_pin;
      sync_b_reg <= sync_a_reg;
      prev_reg   <= sync_b_reg;
    end
  end

  assign hw_rise = sync_b_reg & ~prev_reg;

  always_comb
  begin
    hw_num = tsq_pkg::TSQ_PORT_NONE;
    for (int i = HW_PUSH_N - 1; i >= 0; i--)
    begin
      if (hw_rise[i])
      begin
        hw_num = 5'(i);
      end
    end
  end

  // event sources; all but the software push need the unit running
  assign sw_push_req = wr_push && hwdata[tsq_pkg::TSQ_BIT_PUSH];
  assign roll_req    = unit_enable_bit && (ts_cnt_reg == tsq_pkg::TSQ_CNT_MAX);
  assign half_req    = unit_enable_bit && (ts_cnt_reg == tsq_pkg::TSQ_CNT_HALF);
  assign hw_req      = unit_enable_bit && (|hw_rise);
  assign eth_req     = unit_enable_bit && eth_evt_valid;
  assign n_req = 4'(sw_push_req) + 4'(roll_req) + 4'(half_req)
                 + 4'(hw_req) + 4'(eth_req);

  // one record per cycle; lower priority sources are dropped and flagged
  always_comb
  begin
    cand_valid         = 1'b1;
    cand_rec.stamp     = ts_cnt_reg;
    cand_rec.desc.rsvd = tsq_pkg::TSQ_RSVD;
    cand_rec.desc.port = tsq_pkg::TSQ_PORT_NONE;
    cand_rec.desc.kind = tsq_pkg::TSQ_K_SWPUSH;
    cand_rec.desc.msg  = tsq_pkg::TSQ_MSG_NONE;
    cand_rec.desc.seq  = tsq_pkg::TSQ_SEQ_NONE;
    if (sw_push_req)
    begin
      cand_rec.desc.kind = tsq_pkg::TSQ_K_SWPUSH;
    end
    else if (roll_req)
    begin
      // stamp kept but carries no meaning for rollover
      cand_rec.desc.kind = tsq_pkg::TSQ_K_ROLL;
    end
    else if (half_req)
    begin
      cand_rec.desc.kind = tsq_pkg::TSQ_K_HALF;
    end
    else if (hw_req)
    begin
      cand_rec.desc.kind = tsq_pkg::TSQ_K_HWPUSH;
      cand_rec.desc.port = hw_num;
    end
    else if (eth_req)
    begin
      cand_rec.desc.kind = eth_evt.is_tx ? tsq_pkg::TSQ_K_ETHTX
                                         : tsq_pkg::TSQ_K_ETHRX;
      cand_rec.desc.port = eth_evt.port;
      cand_rec.desc.msg  = eth_evt.msg;
      cand_rec.desc.seq  = eth_evt.seq;
    end
    else
    begin
      cand_valid = 1'b0;
    end
  end

  assign push_fire = cand_valid && push_ready;
  assign lost_evt  = (n_req > 4'h1) || (cand_valid && !push_ready);
  // discard only acts on a queue that holds something
  assign pop_fire  = wr_disc && hwdata[tsq_pkg::TSQ_BIT_DISC]
                     && raw_pending_flag;

  tsq_fifo #(
    .W     ($bits(tsq_pkg::tsq_rec_t)),
    .DEPTH (DEPTH)
  ) u_queue (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (cand_valid),
    .in_data   (cand_rec),
    .in_ready  (push_ready),
    .out_valid (raw_pending_flag),
    .out_ready (pop_fire),
    .out_data  (head_rec),
    .level     (q_level)
  );

  // lost flag: set wins over a same-cycle clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lost_reg <= 1'b0;
    end
    else if (lost_evt)
    begin
      lost_reg <= 1'b1;
    end
    else if (wr_raw && hwdata[tsq_pkg::TSQ_BIT_LOST])
    begin
      lost_reg <= 1'b0;
    end
  end

  assign pending_mask_bit = flag_mask_reg[tsq_pkg::TSQ_BIT_PEND];
  assign raw_irq_flags    = {lost_reg, raw_pending_flag};
  assign masked_irq_flags = raw_irq_flags & flag_mask_reg;
  assign masked_pending_flag = masked_irq_flags[tsq_pkg::TSQ_BIT_PEND];

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |masked_irq_flags;
    end
  end

  // upper word: port only for Ethernet records, cleared for kind code 3
  always_comb
  begin
    hi_desc = head_rec.desc;
    if (head_rec.desc.kind == tsq_pkg::TSQ_K_HWPUSH)
    begin
      hi_desc.port = tsq_pkg::TSQ_PORT_NONE;
    end
  end

  // read mux, unmapped and write-only words read zero
  always_comb
  begin
    rd_val = '0;
    if (acc_addr_reg == tsq_pkg::TSQ_OFF_CTL)
    begin
      rd_val[tsq_pkg::TSQ_BIT_EN] = unit_enable_bit;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_RAW)
    begin
      rd_val[tsq_pkg::TSQ_NFLAG-1:0] = raw_irq_flags;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_MSK)
    begin
      rd_val[tsq_pkg::TSQ_NFLAG-1:0] = masked_irq_flags;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_EN)
    begin
      rd_val[tsq_pkg::TSQ_NFLAG-1:0] = flag_mask_reg;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_LO)
    begin
      rd_val = head_rec.stamp;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_MID)
    begin
      rd_val = head_rec.desc;
    end
    else if (acc_addr_reg == tsq_pkg::TSQ_OFF_HI)
    begin
      rd_val = hi_desc;
    end
    else
    begin
      rd_val = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hrdata_reg <= 32'h0000_0000;
    end
    else if (rd_pend_reg)
    begin
      hrdata_reg <= rd_val;
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = tsq_pkg::TSQ_RESP_OKAY;
  assign irq       = irq_reg;

  // checks
  sequence sw_push_write;
    wr_push && hwdata[tsq_pkg::TSQ_BIT_PUSH] && push_ready;
  endsequence

  sequence discard_no_push;
    pop_fire && !push_fire;
  endsequence

  AST_RAW_SET: assert property (@(posedge core_clk) disable iff (rst)
    push_fire && !raw_pending_flag |=> raw_pending_flag)
    else $error("raw pending did not rise after push");

  AST_RAW_CLR: assert property (@(posedge core_clk) disable iff (rst)
    discard_no_push and (q_level == LW'(1)) |=> !raw_pending_flag)
    else $error("raw pending stayed after last discard");

  AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (rst)
    irq |-> $past(masked_pending_flag || masked_irq_flags[tsq_pkg::TSQ_BIT_LOST]))
    else $error("interrupt without masked cause");

  AST_MASK_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !pending_mask_bit |-> !masked_pending_flag)
    else $error("masked flag high with mask clear");

  AST_MASK_ON: assert property (@(posedge core_clk) disable iff (rst)
    pending_mask_bit && raw_pending_flag && !lost_reg |=> irq)
    else $error("interrupt missing with mask set");

  AST_POP_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
    discard_no_push |=> q_level == $past(q_level) - LW'(1))
    else $error("discard did not remove one record");

  AST_EMPTY_DISC: assert property (@(posedge core_clk) disable iff (rst)
    wr_disc && !raw_pending_flag |=> q_level == $past(q_level) + LW'($past(push_fire)))
    else $error("discard on empty queue changed it");

  AST_ADVANCE: assert property (@(posedge core_clk) disable iff (rst)
    discard_no_push and (q_level > LW'(1)) |=> raw_pending_flag)
    else $error("next record not advanced");

  AST_SW_PUSH: assert property (@(posedge core_clk) disable iff (rst)
    sw_push_write |-> push_fire && cand_rec.stamp == ts_cnt_reg
                      && cand_rec.desc.kind == tsq_pkg::TSQ_K_SWPUSH)
    else $error("software push not stamped at write");

  AST_KIND_LEGAL: assert property (@(posedge core_clk) disable iff (rst)
    push_fire |-> cand_rec.desc.kind <= tsq_pkg::TSQ_K_ETHTX)
    else $error("reserved kind code queued");

  AST_OFF_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !unit_enable_bit ##1 !unit_enable_bit |-> ts_cnt_reg == tsq_pkg::TSQ_CNT_RST)
    else $error("counter ran while unit disabled");

  AST_ETH_FIELDS: assert property (@(posedge core_clk) disable iff (rst)
    push_fire && cand_rec.desc.kind == tsq_pkg::TSQ_K_ETHRX
    |-> cand_rec.desc.seq == eth_evt.seq && cand_rec.desc.msg == eth_evt.msg)
    else $error("ethernet fields not captured");
endmodule // tsq_top
`default_nettype wire

// *** core/tsq_pkg.sv ***
// Purpose: shared constants and types of the time-sync event queue
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes:   record layout follows the three record words
`default_nettype none
package tsq_pkg;
  localparam int unsigned TSQ_DW = 32;
  localparam int unsigned TSQ_AW = 8;
  // register byte offsets
  localparam logic [7:0] TSQ_OFF_CTL  = 8'h00;
  localparam logic [7:0] TSQ_OFF_PUSH = 8'h04;
  localparam logic [7:0] TSQ_OFF_RAW  = 8'h08;
  localparam logic [7:0] TSQ_OFF_MSK  = 8'h0c;
  localparam logic [7:0] TSQ_OFF_EN   = 8'h10;
  localparam logic [7:0] TSQ_OFF_DISC = 8'h14;
  localparam logic [7:0] TSQ_OFF_LO   = 8'h18;
  localparam logic [7:0] TSQ_OFF_MID  = 8'h1c;
  localparam logic [7:0] TSQ_OFF_HI   = 8'h20;
  // bit positions
  localparam int unsigned TSQ_BIT_EN   = 0;
  localparam int unsigned TSQ_BIT_PUSH = 0;
  localparam int unsigned TSQ_BIT_PEND = 0;
  localparam int unsigned TSQ_BIT_LOST = 1;
  localparam int unsigned TSQ_BIT_DISC = 0;
  localparam int unsigned TSQ_NFLAG    = 2;
  localparam logic [1:0] TSQ_FLAG_RST  = 2'h0;
  // bus constants
  localparam int unsigned TSQ_HTRANS_ACT = 1;
  localparam logic [2:0]  TSQ_HSIZE_WORD = 3'h2;
  localparam logic        TSQ_RESP_OKAY  = 1'h0;
  // counter
  localparam logic [31:0] TSQ_CNT_RST  = 32'h0000_0000;
  localparam logic [31:0] TSQ_CNT_ONE  = 32'h0000_0001;
  localparam logic [31:0] TSQ_CNT_MAX  = 32'hffff_ffff;
  localparam logic [31:0] TSQ_CNT_HALF = 32'h7fff_ffff;
  // event kind codes
  localparam logic [3:0] TSQ_K_SWPUSH = 4'h0;
  localparam logic [3:0] TSQ_K_ROLL   = 4'h1;
  localparam logic [3:0] TSQ_K_HALF   = 4'h2;
  localparam logic [3:0] TSQ_K_HWPUSH = 4'h3;
  localparam logic [3:0] TSQ_K_ETHRX  = 4'h4;
  localparam logic [3:0] TSQ_K_ETHTX  = 4'h5;
  localparam logic [4:0] TSQ_PORT_NONE = 5'h00;
  localparam logic [3:0] TSQ_MSG_NONE  = 4'h0;
  localparam logic [15:0] TSQ_SEQ_NONE = 16'h0000;
  localparam logic [2:0] TSQ_RSVD     = 3'h0;

  typedef struct packed {
    logic [2:0]  rsvd;
    logic [4:0]  port;
    logic [3:0]  kind;
    logic [3:0]  msg;
    logic [15:0] seq;
  } tsq_desc_t;

  typedef struct packed {
    tsq_desc_t   desc;
    logic [31:0] stamp;
  } tsq_rec_t;

  typedef struct packed {
    logic        is_tx;
    logic [4:0]  port;
    logic [3:0]  msg;
    logic [15:0] seq;
  } tsq_eth_evt_t;
endpackage
`default_nettype wire

// *** core/tsq_fifo.sv ***
// Purpose: record queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   head word is read straight from the array
`default_nettype none
`timescale 1ns/1ps
module tsq_fifo #(
  parameter int unsigned W     = 64,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        level
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign level     = cnt_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - (AW+1)'(1);
      end
    end
  end
endmodule // tsq_fifo
`default_nettype wire

// *** sim/tsq_tb.sv ***
// Purpose: self-checking bench for the time-sync event queue and its interrupt
// Assumes: AHB-Lite master tasks; hready is looped back from hreadyout
// Notes:   stamps are reckoned from the cycle count of the enabling write
`default_nettype none
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  logic                  core_clk      = 1'b0;
  logic                  rst           = 1'b1;
  logic                  hsel          = 1'b0;
  logic [31:0]           haddr         = 32'h0000_0000;
  logic [1:0]            htrans        = 2'h0;
  logic                  hwrite        = 1'b0;
  logic [2:0]            hsize         = 3'h2;
  logic [31:0]           hwdata        = 32'h0000_0000;
  wire logic             hready;
  logic                  hreadyout;
  logic [31:0]           hrdata;
  logic                  hresp;
  logic [3:0]            hw_push_pin   = 4'h0;
  logic                  eth_evt_valid = 1'b0;
  tsq_pkg::tsq_eth_evt_t eth_evt       = '0;
  logic                  irq;
  int                    n_mismatch    = 0;
  int                    n_checks      = 0;
  int                    cyc           = 0;
  int                    last_cyc;
  int                    c0;
  int                    c1;
  int                    ce0;
  int                    cen;
  int                    ec;
  logic [31:0]           rd;
  logic [31:0]           s0;

  assign hready = hreadyout;

  tsq_top #(.HW_PUSH_N(4), .DEPTH(16)) tsq_top_i (
    .core_clk      (core_clk),
    .rst           (rst),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hready),
    .hreadyout     (hreadyout),
    .hrdata        (hrdata),
    .hresp         (hresp),
    .hw_push_pin   (hw_push_pin),
    .eth_evt_valid (eth_evt_valid),
    .eth_evt       (eth_evt),
    .irq           (irq)
  );

  always #25 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ceiling far above the roughly 180 cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // one single transfer; only the global ceiling ends a hang
  task automatic ahb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= is_wr;
    hsize  <= 3'h2;
    do
    begin
      @(posedge core_clk);
    end
    while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge core_clk);
    end
    while (hready !== 1'b1);
    rd       = hrdata;
    last_cyc = cyc;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(rd & m, e)
  endtask

  // one-cycle event pulse, then a quiet cycle
  task automatic eth(input logic tx, input logic [4:0] p, input logic [3:0] m,
                     input logic [15:0] s);
    eth_evt_valid <= 1'b1;
    eth_evt       <= '{is_tx: tx, port: p, msg: m, seq: s};
    @(posedge core_clk);
    ec = cyc;
    eth_evt_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'hffff_ffff, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_MSK, 32'hffff_ffff, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_EN, 32'hffff_ffff, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_DISC, 32'hffff_ffff, 32'h0000_0000);
    rchk(8'h40, 32'hffff_ffff, 32'h0000_0000);
    `CHK(irq, 1'b0)
    // push while the unit is off: counter held at zero
    wr(tsq_pkg::TSQ_OFF_PUSH, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'h0000_0001, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_MSK, 32'h0000_0001, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(tsq_pkg::TSQ_OFF_EN, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_MSK, 32'h0000_0001, 32'h0000_0001);
    `CHK(irq, 1'b1)
    rchk(tsq_pkg::TSQ_OFF_LO, 32'hffff_ffff, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_MID, 32'hfff0_0000, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_HI, 32'hfff0_0000, 32'h0000_0000);
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'h0000_0001, 32'h0000_0000);
    `CHK(irq, 1'b0)
    // discard on an empty queue must not wrap the pointers
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'hffff_ffff, 32'h0000_0000);
    // unit on: back-to-back pushes, two link events, one pin push
    wr(tsq_pkg::TSQ_OFF_CTL, 32'h0000_0001);
    cen = last_cyc;
    wr(tsq_pkg::TSQ_OFF_PUSH, 32'h0000_0001);
    c0 = last_cyc;
    wr(tsq_pkg::TSQ_OFF_PUSH, 32'h0000_0001);
    c1 = last_cyc;
    eth(1'b0, 5'h03, 4'h2, 16'hbeef);
    ce0 = ec;
    eth(1'b1, 5'h1f, 4'hf, 16'h0001);
    hw_push_pin <= 4'h4;
    repeat (4) @(posedge core_clk);
    hw_push_pin <= 4'h0;
    @(posedge core_clk);
    // counter is zero in the cycle after the enabling edge, then counts
    s0 = 32'(c0 - cen - 1);
    rchk(tsq_pkg::TSQ_OFF_LO, 32'hffff_ffff, s0);
    rchk(tsq_pkg::TSQ_OFF_HI, 32'hfff0_0000, 32'h0000_0000);
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_LO, 32'hffff_ffff, s0 + 32'(c1 - c0));
    rchk(tsq_pkg::TSQ_OFF_HI, 32'hfff0_0000, 32'h0000_0000);
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_LO, 32'hffff_ffff, s0 + 32'(ce0 - c0));
    rchk(tsq_pkg::TSQ_OFF_MID, 32'hffff_ffff, {3'h0, 5'h03, 4'h4, 4'h2, 16'hbeef});
    rchk(tsq_pkg::TSQ_OFF_HI, 32'hffff_ffff, {3'h0, 5'h03, 4'h4, 4'h2, 16'hbeef});
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_MID, 32'hffff_ffff, {3'h0, 5'h1f, 4'h5, 4'hf, 16'h0001});
    rchk(tsq_pkg::TSQ_OFF_HI, 32'hffff_ffff, {3'h0, 5'h1f, 4'h5, 4'hf, 16'h0001});
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_MID, 32'hfff0_0000, 32'h0230_0000);
    rchk(tsq_pkg::TSQ_OFF_HI, 32'h1f00_0000, 32'h0000_0000);
    wr(tsq_pkg::TSQ_OFF_DISC, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'h0000_0001, 32'h0000_0000);
    `CHK(irq, 1'b0)
    // unit off again: stamp back to zero; mask cleared with a record pending
    wr(tsq_pkg::TSQ_OFF_CTL, 32'h0000_0000);
    wr(tsq_pkg::TSQ_OFF_PUSH, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_LO, 32'hffff_ffff, 32'h0000_0000);
    `CHK(irq, 1'b1)
    wr(tsq_pkg::TSQ_OFF_EN, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_EN, 32'h0000_0001, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_MSK, 32'h0000_0001, 32'h0000_0000);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'h0000_0001, 32'h0000_0001);
    `CHK(irq, 1'b0)
    // sixteen more pushes overrun the queue: the last is dropped and flagged
    repeat (16) wr(tsq_pkg::TSQ_OFF_PUSH, 32'h0000_0001);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'hffff_ffff, 32'h0000_0003);
    wr(tsq_pkg::TSQ_OFF_EN, 32'h0000_0002);
    rchk(tsq_pkg::TSQ_OFF_MSK, 32'hffff_ffff, 32'h0000_0002);
    `CHK(irq, 1'b1)
    wr(tsq_pkg::TSQ_OFF_RAW, 32'h0000_0002);
    rchk(tsq_pkg::TSQ_OFF_RAW, 32'hffff_ffff, 32'h0000_0001);
    `CHK(irq, 1'b0)
    print_verdict();
  end
endmodule // tb
`default_nettype wire
